// ==== hw/bsac_pkg.sv ====
/*
  Constants for the branch sequencer and alarm controller: register map,
  field layouts, reset values, timing constants and mode encodings.
  Assumes a 40 MHz APB clock.
*/
package bsac_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned TICK_MS       = 1;
  localparam int unsigned TICK_CYC      = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned BLANK_MS      = 70;
  localparam int unsigned OT_HOLD_MS    = 1000;
  localparam int unsigned STEP_MS       = 100;
  localparam int unsigned RUN_UNIT_MS   = 360000000;
  // ---------------------------------------------------------------
  // Setting limits
  // ---------------------------------------------------------------
  localparam logic [9:0]  RT_MAX        = 10'h3E7;
  localparam logic [9:0]  DLY_MAX       = 10'h3DE;
  localparam logic [7:0]  OT_MIN        = 8'h19;
  localparam logic [7:0]  OT_MAX        = 8'h50;
  localparam logic [7:0]  TEMP_MIN      = 8'hF6;
  localparam logic [7:0]  TEMP_MAX      = 8'h64;
  localparam logic [7:0]  OT_HYST       = 8'h02;
  localparam logic [7:0]  OT_RST        = 8'h3C;
  localparam logic [9:0]  RT_RST        = 10'h3E7;
  localparam logic [9:0]  DLY_RST       = 10'h000;
  localparam logic [7:0]  CODE_OT       = 8'h30;
  localparam logic [7:0]  CODE_RT       = 8'h23;
  localparam int unsigned BLINK_MS      = 500;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0]  A_CTRL   = 8'h00;
  localparam logic [7:0]  A_STAT   = 8'h04;
  localparam logic [7:0]  A_IRQ    = 8'h08;
  localparam logic [7:0]  A_MASK   = 8'h0C;
  localparam logic [7:0]  A_RTSET  = 8'h10;
  localparam logic [7:0]  A_OTSET  = 8'h14;
  localparam logic [7:0]  A_RUNT   = 8'h18;
  localparam logic [7:0]  A_DISP   = 8'h1C;
  localparam logic [7:0]  A_ONDLY  = 8'h20;
  localparam logic [7:0]  A_OFFDLY = 8'h30;
  // CTRL fields
  localparam int C_MODE = 0;
  localparam int C_TEST = 4;
  localparam int C_RTCLR = 8;
  // IRQ bits
  localparam int I_RT   = 0;
  localparam int I_OT   = 1;
  localparam int I_ON   = 2;
  localparam int I_OFF  = 3;
  localparam int I_W    = 4;
  typedef enum logic [1:0] {
    BSAC_SET  = 2'b00,
    BSAC_RUN  = 2'b01,
    BSAC_TEST = 2'b11
  } bsac_mode_t;
endpackage

// ==== hw/bsac_top.sv ====
/*
  Branch sequencer and alarm controller: staggered per-branch connect
  and disconnect, inrush blanking, run time and over-temperature alarms,
  operating mode selection, APB register slave and interrupt.
  Assumes inputs synchronous to pclk, temperature as signed degrees C.
*/
// Operation
// R1: Run time preset 0..99.9 kh, 0.1 kh
// R2: Overtemp output after above threshold over 1 s
// R3: Display alternates temperature and overtemp code
// R4: Overtemp clears itself below threshold, hysteresis
// R5: Overtemp threshold 25..80 C, 1 C steps
// R6: Temperature shown -10..100 C, 1 C
// R7: Alarms never disconnect branches
// R8: Alarm outputs conduct normally, open on alarm
// R9: Startup connects each branch after own delay
// R10: Trip or stop disconnects after own delay
// R11: Current trip blanked 70 ms after connect
// R12: Sequencing only for own four branches
// R13: Overvoltage trip disconnects all at once
// R14: Run, setting and test modes
// R15: First power-up in setting, then test/run
// R16: Run time accumulates; alarm at preset
// R17: Shutdown delay counts from trip detection
`timescale 1ns/1ps
`default_nettype none
module bsac_top
  import bsac_pkg::*;
#(
  parameter int unsigned NBR       = 4,
  parameter int unsigned TICK_CYCP = TICK_CYC,
  parameter int unsigned RUN_UNITP = RUN_UNIT_MS / TICK_MS
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              ext_trip,
  input  wire logic              estop,
  input  wire logic              overvolt_trip,
  input  wire logic signed [7:0] temp_c,
  output logic      [NBR-1:0]    branch_on,
  output logic      [NBR-1:0]    trip_enable,
  output logic                   alarm_output,
  output logic                   overtemp_output,
  output logic      [7:0]        disp_value,
  output logic                   disp_is_code,
  output logic                   irq
);
  localparam int unsigned STEP_T  = STEP_MS / TICK_MS;
  localparam int unsigned BLANK_T = BLANK_MS / TICK_MS;
  localparam int unsigned OT_T    = OT_HOLD_MS / TICK_MS;
  localparam int unsigned BLINK_T = BLINK_MS / TICK_MS;

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  bsac_mode_t        mode_r, mode_nxt;
  logic [NBR-1:0]    test_r, test_nxt;
  logic [9:0]        rtset_r, rtset_nxt;
  logic [7:0]        otset_r, otset_nxt;
  logic [9:0]        ondly_r [NBR], ondly_nxt [NBR];
  logic [9:0]        offdly_r [NBR], offdly_nxt [NBR];
  logic [I_W-1:0]    irq_r, irq_nxt, mask_r, mask_nxt;
  logic [31:0]       prdata_nxt;
  logic [15:0]       tick_cnt_r, tick_cnt_nxt;
  logic              tick;
  logic [6:0]        step_cnt_r, step_cnt_nxt;
  logic              step;
  logic [31:0]       unit_cnt_r, unit_cnt_nxt;
  logic [9:0]        runt_r, runt_nxt;
  logic              rt_alm;
  logic              ot_r, ot_nxt;
  logic [10:0]       ot_cnt_r, ot_cnt_nxt;
  logic [9:0]        blink_r, blink_nxt;
  logic              phase_r, phase_nxt;
  logic              down_r, down_nxt;
  logic [9:0]        seq_cnt_r [NBR], seq_cnt_nxt [NBR];
  logic [NBR-1:0]    on_r, on_nxt;
  logic [6:0]        blank_r [NBR], blank_nxt [NBR];
  logic [7:0]        disp_nxt;
  logic              code_nxt;
  logic              wr, rd;
  logic [7:0]        tclamp;

  assign wr      = psel & penable & pwrite;
  assign rd      = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign tick    = (tick_cnt_r == 16'(TICK_CYCP - 1));
  assign step    = tick & (step_cnt_r == 7'(STEP_T - 1));
  assign rt_alm  = (runt_r >= rtset_r);                                          // R16

  // Clamp reading to displayable span
  always_comb begin
    if ($signed(temp_c) < $signed(TEMP_MIN)) tclamp = TEMP_MIN;                  // R6
    else if ($signed(temp_c) > $signed(TEMP_MAX)) tclamp = TEMP_MAX;
    else tclamp = temp_c;
  end

  // -----------------------------------------------------------------
  // Registers and APB
  // -----------------------------------------------------------------
  always_comb begin
    mode_nxt   = mode_r;
    test_nxt   = test_r;
    rtset_nxt  = rtset_r;
    otset_nxt  = otset_r;
    mask_nxt   = mask_r;
    ondly_nxt  = ondly_r;
    offdly_nxt = offdly_r;
    prdata_nxt = prdata;
    irq_nxt    = irq_r;
    if (wr && mode_r != BSAC_RUN) begin                                          // R14
      unique case (paddr)
        A_CTRL: begin
          if (pwdata[C_MODE+1:C_MODE] != 2'b10)                                  // R15
            mode_nxt = bsac_mode_t'(pwdata[C_MODE+1:C_MODE]);
          test_nxt = pwdata[C_TEST+NBR-1:C_TEST];
        end
        A_RTSET: if (pwdata[9:0] <= RT_MAX) rtset_nxt = pwdata[9:0];             // R1
        A_OTSET: if (pwdata[7:0] >= OT_MIN && pwdata[7:0] <= OT_MAX)
          otset_nxt = pwdata[7:0];                                               // R5
        default: ;
      endcase
      for (int i = 0; i < NBR; i++) begin
        if (paddr == A_ONDLY + 8'(4*i) && pwdata[9:0] <= DLY_MAX)                // R9
          ondly_nxt[i] = pwdata[9:0];
        if (paddr == A_OFFDLY + 8'(4*i) && pwdata[9:0] <= DLY_MAX)               // R10
          offdly_nxt[i] = pwdata[9:0];
      end
    end else if (wr && paddr == A_CTRL) begin
      if (pwdata[C_MODE+1:C_MODE] == BSAC_SET) mode_nxt = BSAC_SET;
    end
    if (wr && paddr == A_MASK) mask_nxt = pwdata[I_W-1:0];
    if (wr && paddr == A_IRQ) irq_nxt = irq_r & ~pwdata[I_W-1:0];
    // Set beats clear
    irq_nxt[I_RT]  = irq_nxt[I_RT] | ((runt_nxt >= rtset_nxt) & ~rt_alm);        // R16
    irq_nxt[I_OT]  = irq_nxt[I_OT] | (ot_nxt & ~ot_r);
    irq_nxt[I_ON]  = irq_nxt[I_ON] | (|(on_nxt & ~on_r));
    irq_nxt[I_OFF] = irq_nxt[I_OFF] | (|(~on_nxt & on_r));
    if (rd) begin
      unique case (paddr)
        A_CTRL:  prdata_nxt = {28'h0, 2'b00, mode_r} | (32'(test_r) << C_TEST);
        A_STAT:  prdata_nxt = {24'h0, 2'(0), down_r, ot_r, rt_alm, 3'(0)}
                              | (32'(on_r) << 8) | (32'(trip_enable) << 12);
        A_IRQ:   prdata_nxt = 32'(irq_r);
        A_MASK:  prdata_nxt = 32'(mask_r);
        A_RTSET: prdata_nxt = 32'(rtset_r);
        A_OTSET: prdata_nxt = 32'(otset_r);
        A_RUNT:  prdata_nxt = 32'(runt_r);
        A_DISP:  prdata_nxt = {23'h0, disp_is_code, disp_value};
        default: prdata_nxt = 32'h0000_0000;
      endcase
      for (int i = 0; i < NBR; i++) begin
        if (paddr == A_ONDLY + 8'(4*i)) prdata_nxt = 32'(ondly_r[i]);
        if (paddr == A_OFFDLY + 8'(4*i)) prdata_nxt = 32'(offdly_r[i]);
      end
    end
  end

  // -----------------------------------------------------------------
  // Time base, run time, over-temperature, display
  // -----------------------------------------------------------------
  always_comb begin
    tick_cnt_nxt = tick ? 16'h0000 : tick_cnt_r + 16'h0001;
    step_cnt_nxt = !tick ? step_cnt_r : (step ? 7'h00 : step_cnt_r + 7'h01);
    unit_cnt_nxt = unit_cnt_r;
    runt_nxt     = runt_r;
    if (tick) begin                                                              // R16
      if (unit_cnt_r == RUN_UNITP - 1) begin
        unit_cnt_nxt = 32'h0;
        if (runt_r != RT_MAX) runt_nxt = runt_r + 10'h001;
      end else unit_cnt_nxt = unit_cnt_r + 32'h1;
    end
    ot_cnt_nxt = ot_cnt_r;
    ot_nxt     = ot_r;
    if ($signed(temp_c) > $signed(otset_r)) begin                                // R2
      if (tick && ot_cnt_r != 11'(OT_T)) ot_cnt_nxt = ot_cnt_r + 11'h001;
      if (ot_cnt_r == 11'(OT_T)) ot_nxt = 1'b1;
    end else begin
      ot_cnt_nxt = 11'h000;
      if ($signed(temp_c) < $signed(otset_r - OT_HYST)) ot_nxt = 1'b0;           // R4
    end
    blink_nxt = blink_r;
    phase_nxt = phase_r;
    if (tick) begin
      if (blink_r == 10'(BLINK_T - 1)) begin
        blink_nxt = 10'h000;
        phase_nxt = ~phase_r;
      end else blink_nxt = blink_r + 10'h001;
    end
    disp_nxt = tclamp;                                                           // R6
    code_nxt = 1'b0;
    if (ot_r) begin                                                              // R3
      disp_nxt = phase_r ? CODE_OT : tclamp;
      code_nxt = phase_r;
    end else if (rt_alm) begin                                                   // R16
      disp_nxt = phase_r ? CODE_RT : runt_r[7:0];
      code_nxt = phase_r;
    end
  end

  // -----------------------------------------------------------------
  // Branch sequencing
  // -----------------------------------------------------------------
  always_comb begin
    down_nxt = down_r | ext_trip | estop;                                        // R17
    if (mode_r != BSAC_RUN) down_nxt = 1'b0;
    on_nxt      = on_r;
    seq_cnt_nxt = seq_cnt_r;
    for (int i = 0; i < NBR; i++) begin                                          // R12
      if (mode_r == BSAC_TEST) begin
        on_nxt[i] = test_r[i];
        seq_cnt_nxt[i] = 10'h000;
      end else if (mode_r == BSAC_RUN && !down_nxt) begin                        // R9
        if (!on_r[i]) begin
          if (seq_cnt_r[i] >= ondly_r[i]) on_nxt[i] = 1'b1;
          else if (step) seq_cnt_nxt[i] = seq_cnt_r[i] + 10'h001;
        end
      end else if (down_nxt && on_r[i]) begin                                    // R10
        if (!down_r) seq_cnt_nxt[i] = 10'h000;
        else if (seq_cnt_r[i] >= offdly_r[i]) on_nxt[i] = 1'b0;
        else if (step) seq_cnt_nxt[i] = seq_cnt_r[i] + 10'h001;
      end
      // Fresh start delay on every entry to Run
      if (mode_r == BSAC_SET) seq_cnt_nxt[i] = 10'h000;                          // R9
      if (overvolt_trip) on_nxt[i] = 1'b0;                                       // R13
      // Alarms take no part in branch state                                     // R7
    end
  end

  // -----------------------------------------------------------------
  // Inrush blanking, one counter per branch
  // -----------------------------------------------------------------
  for (genvar g = 0; g < NBR; g++) begin : g_blank
    always_comb begin
      blank_nxt[g] = blank_r[g];
      if (!on_nxt[g]) begin
        blank_nxt[g] = 7'h00;
      end else if (tick && blank_r[g] != 7'(BLANK_T)) begin                      // R11
        blank_nxt[g] = blank_r[g] + 7'h01;
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        blank_r[g] <= 7'h00;
      end else begin
        blank_r[g] <= blank_nxt[g];
      end
    end
    assign trip_enable[g] = on_r[g] && blank_r[g] == 7'(BLANK_T);               // R11
  end

  assign branch_on       = on_r;
  assign alarm_output    = ~rt_alm;                                              // R8
  assign overtemp_output = ~ot_r;                                                // R8
  assign irq             = |(irq_r & mask_r);

  // -----------------------------------------------------------------
  // Flip-flops
  // -----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r     <= BSAC_SET;                                                    // R15
      test_r     <= '0;
      rtset_r    <= RT_RST;
      otset_r    <= OT_RST;
      mask_r     <= '0;
      irq_r      <= '0;
      prdata     <= 32'h0000_0000;
      tick_cnt_r <= 16'h0000;
      step_cnt_r <= 7'h00;
      unit_cnt_r <= 32'h0;
      runt_r     <= 10'h000;
      ot_r       <= 1'b0;
      ot_cnt_r   <= 11'h000;
      blink_r    <= 10'h000;
      phase_r    <= 1'b0;
      down_r     <= 1'b0;
      on_r       <= '0;
      disp_value <= 8'h00;
      disp_is_code <= 1'b0;
      for (int i = 0; i < NBR; i++) begin
        ondly_r[i]   <= DLY_RST;
        offdly_r[i]  <= DLY_RST;
        seq_cnt_r[i] <= 10'h000;
      end
    end else begin
      mode_r     <= mode_nxt;
      test_r     <= test_nxt;
      rtset_r    <= rtset_nxt;
      otset_r    <= otset_nxt;
      mask_r     <= mask_nxt;
      irq_r      <= irq_nxt;
      prdata     <= prdata_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      step_cnt_r <= step_cnt_nxt;
      unit_cnt_r <= unit_cnt_nxt;
      runt_r     <= runt_nxt;
      ot_r       <= ot_nxt;
      ot_cnt_r   <= ot_cnt_nxt;
      blink_r    <= blink_nxt;
      phase_r    <= phase_nxt;
      down_r     <= down_nxt;
      on_r       <= on_nxt;
      disp_value <= disp_nxt;
      disp_is_code <= code_nxt;
      ondly_r    <= ondly_nxt;
      offdly_r   <= offdly_nxt;
      seq_cnt_r  <= seq_cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/bsac_chk_sva.sv ====
/* Port checker for bsac_top.
   Assumes it is bound into bsac_top, one pclk domain. */
`timescale 1ns/1ps
`default_nettype none
module bsac_chk
  import bsac_pkg::*;
#(
  parameter int unsigned TICK_CYCP = 4
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              pready,
  input wire logic              ext_trip,
  input wire logic              estop,
  input wire logic              overvolt_trip,
  input wire logic signed [7:0] temp_c,
  input wire logic [3:0]        branch_on,
  input wire logic [3:0]        trip_enable,
  input wire logic              alarm_output,
  input wire logic              overtemp_output,
  input wire logic [7:0]        disp_value,
  input wire logic              disp_is_code
);
  int unsigned blank_r, blank_nxt, hot_r, hot_nxt;
  // ------------------------------------------------
  // Dwell counters for blanking and heat
  // ------------------------------------------------
  always_comb begin
    blank_nxt = (branch_on[0] && !trip_enable[0]) ? blank_r + 1 : 0;
    hot_nxt   = (temp_c > $signed(OT_MIN)) ? hot_r + 1 : 0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_r <= 0;
      hot_r   <= 0;
    end else begin
      blank_r <= blank_nxt;
      hot_r   <= hot_nxt;
    end
  end
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_ovt_all_off: assert property (overvolt_trip |=> branch_on == 4'h0)
    else $error("branches left on after overvoltage");
  a_trip_subset: assert property ((trip_enable & ~branch_on) == 4'h0)
    else $error("trip enabled on open branch");
  a_blank_min: assert property ($rose(trip_enable[0]) |-> blank_r >= 69 * TICK_CYCP)
    else $error("blanking too short");
  a_blank_max: assert property (blank_r <= 71 * TICK_CYCP)
    else $error("blanking too long");
  a_ot_hold: assert property ($fell(overtemp_output) |-> hot_r >= 999 * TICK_CYCP)
    else $error("overtemp without one second dwell");
  a_code_shown: assert property (disp_is_code && disp_value == CODE_OT
    |-> !overtemp_output || !$past(overtemp_output))
    else $error("overtemp code without alarm");
  a_alarm_keeps: assert property (($fell(alarm_output) || $fell(overtemp_output))
    && !ext_trip && !estop && !overvolt_trip |-> $stable(branch_on))
    else $error("alarm moved a branch");
endmodule
bind bsac_top bsac_chk #(.TICK_CYCP(TICK_CYCP)) chk_u (.pclk, .presetn, .pready, .ext_trip,
  .estop, .overvolt_trip, .temp_c, .branch_on, .trip_enable, .alarm_output,
  .overtemp_output, .disp_value, .disp_is_code);
`default_nettype wire

// ==== testbench/bsac_load_mon.sv ====
/* Load side and alarm monitor model: stop requests and fan control.
   Assumes requests from the bench, one pclk domain. */
`timescale 1ns/1ps
`default_nettype none
module bsac_load_mon (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] stop_req,
  input  wire logic       overtemp_output,
  output logic            ext_trip,
  output logic            estop,
  output logic            fan_on
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_trip <= 1'b0;
      estop    <= 1'b0;
    end else begin
      ext_trip <= stop_req[0];
      estop    <= stop_req[1];
    end
  end
  assign fan_on = !overtemp_output;
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
/* Self-checking bench for bsac_top.
   Assumes short tick parameters and the load monitor model. */
`timescale 1ns/1ps
`default_nettype none
module tb
  import bsac_pkg::*;
;
  localparam int TK = 4;
  localparam int ST = STEP_MS * TK;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic              overvolt_trip, alarm_output, overtemp_output, disp_is_code;
  logic              irq, ext_trip, estop, fan_on;
  logic [7:0]        paddr, disp_value;
  logic [31:0]       pwdata, prdata, q, rt;
  logic signed [7:0] temp_c;
  logic [3:0]        branch_on, trip_enable, tb_bits;
  logic [1:0]        stop_req;
  logic [31:0]       dn [4], df [4];
  logic [31:0]       z [4] = '{32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0]       ov [5] = '{32'h18, 32'h51, 32'h19, 32'h50, 32'h3C};
  logic [31:0]       oe [5] = '{32'h3C, 32'h3C, 32'h19, 32'h50, 32'h3C};
  int                n_mismatch = 0, cmp_count = 0, cyc = 0, seed, t0, n;
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  bsac_top #(.TICK_CYCP(TK), .RUN_UNITP(50)) dut_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_trip, .estop, .overvolt_trip,
    .temp_c, .branch_on, .trip_enable, .alarm_output, .overtemp_output, .disp_value,
    .disp_is_code, .irq);
  bsac_load_mon mon_u (.pclk, .presetn, .stop_req, .overtemp_output, .ext_trip, .estop,
    .fan_on);
  // ------------------------------------------------
  // Bus, wait and compare helpers
  // ------------------------------------------------
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic bad(input string s);
    n_mismatch++;
    $display("wrong value at %0t: %s", $time, s);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) bad($sformatf("got %h exp %h", g, e));
  endtask
  task automatic chk_t(input int g, input int e, input int tol);
    cmp_count++;
    if (g < e - tol || g > e + tol) bad($sformatf("took %0d exp %0d", g, e));
  endtask
  task automatic guard();
    if (n >= 8000) begin
      bad("wait timed out");
      test_done();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 8000);
    guard();
    q = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic wt(ref logic s, input logic v, input int lim);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (s !== v && n < lim);
    if (n >= lim) n = 8000;
    guard();
  endtask
  task automatic seq(input logic [3:0] tg, input logic [31:0] d [4]);
    logic [3:0] seen;
    seen = 4'h0;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
      for (int i = 0; i < 4; i++) begin
        if (!seen[i] && branch_on[i] === tg[i]) begin
          seen[i] = 1'b1;
          chk_t(cyc - t0, int'(d[i]) * ST, ST + 8);
        end
      end
    end while (seen !== 4'hF && n < 8000);
    guard();
  endtask
  task automatic start();
    wr(A_CTRL, 32'h0);
    wr(A_CTRL, 32'h1);
    t0 = cyc;
    seq(4'hF, dn);
  endtask
  task automatic stop(input logic [1:0] r);
    @(posedge pclk);
    stop_req <= r;
    @(posedge pclk);
    stop_req <= 2'b00;
    t0 = cyc;
    seq(4'h0, df);
  endtask
  initial begin
    seed = 2834;
    {psel, penable, pwrite, overvolt_trip, paddr, pwdata} = '0;
    temp_c = 8'sh14;
    stop_req = 2'b00;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk({branch_on, alarm_output, overtemp_output, irq}, 32'h6);
    rdc(A_CTRL, 32'h0);
    rdc(A_RTSET, 32'(RT_RST));
    rdc(8'h40, 32'h0);
    chk(pslverr, 32'h0);
    foreach (ov[i]) begin
      wr(A_OTSET, ov[i]);
      rdc(A_OTSET, oe[i]);
    end
    wr(A_OFFDLY, 32'h3DF);
    rdc(A_OFFDLY, 32'h0);
    wr(A_OFFDLY, 32'(DLY_MAX));
    rdc(A_OFFDLY, 32'(DLY_MAX));
    for (int i = 0; i < 4; i++) begin
      dn[i] = (i == 0) ? 32'h0 : 32'($unsigned($random(seed)) % 3 + 1);
      df[i] = 32'($unsigned($random(seed)) % 3 + 1);
      wr(A_ONDLY + 8'(4 * i), dn[i]);
      wr(A_OFFDLY + 8'(4 * i), df[i]);
    end
    tb_bits = 4'($random(seed));
    wr(A_CTRL, 32'h2);
    rdc(A_CTRL, 32'h0);
    wr(A_CTRL, {24'h0, tb_bits, 4'h3});
    t0 = cyc;
    seq(tb_bits, z);
    wr(A_CTRL, 32'h3);
    wr(A_MASK, 32'h4);
    wr(A_IRQ, 32'hF);
    start();
    repeat (300) @(negedge pclk);
    chk({irq, trip_enable}, 32'h1F);
    rdc(A_IRQ, 32'h4);
    wr(A_IRQ, 32'h4);
    wt(irq, 1'b0, 20);
    wr(A_OTSET, 32'h32);
    rdc(A_OTSET, 32'h3C);
    stop(2'b01);
    chk(irq, 32'h0);
    rdc(A_IRQ, 32'h8);
    start();
    wr(A_IRQ, 32'hF);
    @(posedge pclk);
    temp_c <= 8'(61 + $unsigned($random(seed)) % 40);
    t0 = cyc;
    wt(overtemp_output, 1'b0, 6000);
    chk_t(cyc - t0, OT_HOLD_MS * TK, 2 * TK + 2);
    chk({fan_on, branch_on}, 32'h1F);
    rdc(A_IRQ, 32'h2);
    wt(disp_is_code, 1'b1, 3000);
    chk(disp_value, CODE_OT);
    wt(disp_is_code, 1'b0, 3000);
    chk(disp_value, temp_c);
    @(posedge pclk);
    temp_c <= 8'sh3B;
    repeat (200) @(negedge pclk);
    chk(overtemp_output, 32'h0);
    @(posedge pclk);
    temp_c <= 8'sh39;
    wt(overtemp_output, 1'b1, 6000);
    stop(2'b10);
    start();
    @(posedge pclk);
    overvolt_trip <= 1'b1;
    @(negedge pclk);
    @(negedge pclk);
    chk(branch_on, 32'h0);
    @(posedge pclk);
    overvolt_trip <= 1'b0;
    wr(A_CTRL, 32'h0);
    rt = 32'(1 + $unsigned($random(seed)) % 40);
    wr(A_IRQ, 32'hF);
    wr(A_RTSET, rt);
    wt(alarm_output, 1'b0, 200);
    rdc(A_IRQ, 32'h1);
    apb(1'b0, A_RUNT, 32'h0);
    chk(32'(q >= rt), 32'h1);
    wr(A_RTSET, 32'h3E8);
    rdc(A_RTSET, rt);
    test_done();
  end
endmodule
`default_nettype wire
